// ==== bench/cni_host_model.sv ====
`timescale 1ns/10ps

// ****************************************
// host input side: times alert pulses and led blinks
// ****************************************
module cni_host_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic alert_n,
    input wire logic notify,
    input wire logic led,
    output int low_w,
    output int fall_per,
    output int notify_cnt,
    output int led_hi,
    output int led_per,
    output int led_rises
);
    logic alert_p;
    logic led_p;
    int low_run;
    int a_cnt;
    int hi_run;
    int l_cnt;

    // widths are latched on the closing edge, so read them a cycle late
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            alert_p <= 1'b1;
            led_p <= 1'b0;
            {low_run, a_cnt, hi_run, l_cnt} <= '0;
            {low_w, fall_per, notify_cnt} <= '0;
            {led_hi, led_per, led_rises} <= '0;
        end else begin
            alert_p <= alert_n;
            led_p <= led;
            low_run <= alert_n ? 0 : low_run + 1;
            hi_run <= led ? hi_run + 1 : 0;
            a_cnt <= (alert_p && !alert_n) ? 1 : a_cnt + 1;
            l_cnt <= (!led_p && led) ? 1 : l_cnt + 1;
            if (alert_p && !alert_n) begin
                fall_per <= a_cnt;
            end
            if (!alert_p && alert_n) begin
                low_w <= low_run;
            end
            if (!led_p && led) begin
                led_per <= l_cnt;
                led_rises <= led_rises + 1;
            end
            if (led_p && !led) begin
                led_hi <= hi_run;
            end
            if (notify) begin
                notify_cnt <= notify_cnt + 1;
            end
        end
    end
endmodule : cni_host_model

// ==== bench/tb.sv ====
`timescale 1ns/10ps
`include "cni_regs.svh"

module tb;
    import cni_pkg::*;
    localparam int unsigned TC = 4;
    localparam int LIMIT = 98000;
    typedef struct {logic pen; cni_net_t st; int per; int on;} cni_row_t;

    logic clk_sys;
    logic rstn;
    cni_evt_t evt;
    cni_net_cfg_t net_cfg;
    logic alert_n;
    logic notify;
    logic led;
    int low_w, fall_per, notify_cnt, led_hi, led_per, led_rises;
    int fail_count = 0;
    int n_checks = 0;
    int cyc_cnt = 0;
    int r0;
    int n0;
    cni_row_t rows[6];

    cni_indicator #(.TICK_CYC(TC)) u_dut (.clk_sys(clk_sys), .rstn(rstn), .evt(evt), .net_cfg(net_cfg),
        .call_alert_n_out(alert_n), .ring_notify_out(notify), .network_status_led_out(led));

    cni_host_model u_host (.clk_sys(clk_sys), .rstn(rstn), .alert_n(alert_n), .notify(notify), .led(led),
        .low_w(low_w), .fall_per(fall_per), .notify_cnt(notify_cnt), .led_hi(led_hi), .led_per(led_per),
        .led_rises(led_rises));

    // ****************************************
    // helpers
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t %s seen %0d exp %0d", $time, msg, seen, exp);
        end
    endtask : check

    task automatic wait_alert(input logic v, input int lim);
        for (int i = 0; i < lim && alert_n !== v; i++) cyc(1);
    endtask : wait_alert

    task final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // a hang costs one mismatch, then the normal verdict
    always @(posedge clk_sys) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == LIMIT) begin
            fail_count++;
            final_report();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rstn = 1'b0;
        evt = '0;
        net_cfg = '0;
        rows = '{'{1'b0, NET_OFF, 0, 0}, '{1'b0, NET_SEARCH, `CNI_DEF_PER_MS * TC, `CNI_DEF_ON_MS * TC},
            '{1'b1, NET_OFF, 0, 0}, '{1'b1, NET_SEARCH, `CNI_SRCH_PER_MS * TC, `CNI_SRCH_ON_MS * TC},
            '{1'b1, NET_REG, `CNI_REG_PER_MS * TC, `CNI_REG_ON_MS * TC},
            '{1'b1, NET_DATA, `CNI_DATA_PER_MS * TC, `CNI_DATA_ON_MS * TC}};
        cyc(2);
        check(alert_n, 1, "alert in reset");
        check({notify, led}, 0, "outputs in reset");
        rstn = 1'b1;
        foreach (rows[k]) begin
            net_cfg.pattern_en = rows[k].pen;
            net_cfg.state = rows[k].st;
            r0 = led_rises;
            if (rows[k].per == 0) begin
                cyc(300);
                check(led_rises - r0 + led, 0, "led off");
            end else begin
                // third rise: the first period may be cut by the switch
                for (int i = 0; i < 4 * rows[k].per && led_rises < r0 + 3; i++) cyc(1);
                check(led_per, rows[k].per, "led period");
                check(led_hi, rows[k].on, "led on time");
            end
        end
        net_cfg = '0;
        cyc(2);
        n0 = notify_cnt;
        evt.call_ringing = 1'b1;
        wait_alert(0, 4);
        check(alert_n, 0, "call fall");
        for (int i = 0; i < 5001 * TC && notify_cnt < n0 + 2; i++) cyc(1);
        check(low_w, `CNI_CALL_LOW_MS * TC, "call low width");
        check(fall_per, `CNI_CALL_PER_MS * TC, "call period");
        check(notify_cnt - n0, 2, "ring notices");
        cyc(10);
        evt.call_ringing = 1'b0;
        cyc(2);
        check(alert_n, 1, "answered mid pulse");
        cyc(300);
        check(alert_n, 1, "answered stays high");
        check(notify_cnt - n0, 2, "no notice after answer");
        evt.sms_arrived = 1'b1;
        cyc(1);
        evt.sms_arrived = 1'b0;
        wait_alert(0, 4);
        check(alert_n, 0, "sms fall");
        cyc(10);
        evt.sms_arrived = 1'b1;
        cyc(1);
        evt.sms_arrived = 1'b0;
        wait_alert(1, `CNI_SMS_LOW_MS * TC + 5);
        cyc(1);
        check(low_w, `CNI_SMS_LOW_MS * TC, "sms low width");
        cyc(200);
        check(alert_n, 1, "single sms pulse");
        check(notify_cnt - n0, 2, "sms gives no notice");
        evt.call_ringing = 1'b1;
        wait_alert(0, 4);
        cyc(7);
        rstn = 1'b0;
        cyc(1);
        check(alert_n, 1, "alert in second reset");
        rstn = 1'b1;
        wait_alert(0, 4);
        wait_alert(1, `CNI_CALL_LOW_MS * TC + 5);
        cyc(1);
        check(low_w, `CNI_CALL_LOW_MS * TC, "width after reset");
        evt.call_ringing = 1'b0;
        cyc(2);
        final_report();
    end
endmodule : tb

// ==== core/cni_indicator.sv ====
`timescale 1ns/10ps
`include "cni_regs.svh"

// Contract
// [R1] unanswered incoming call drives alert output low in 30 ms pulses
// [R2] call low pulses repeat every 5 seconds while the call stays unanswered
// [R3] answered call stops pulsing, alert output held high
// [R4] each call pulse also requests a textual ring notice on the serial port
// [R5] text message arrival gives one 35 ms low pulse, then high; the code drops an arrival that comes while a call rings
// [R6] network led is a pwm wave whose duty and rate follow network state; without pattern_en one default blink in all but NET_OFF
// [R7] host command enables distinct blink pattern per network state
// [R8] alert output rests high when idle and right after reset
// [R9] all widths and periods count a prescaled millisecond tick cleared by reset

module cni_indicator #(
    parameter int unsigned TICK_CYC = `CNI_TICK_NS / `CNI_CLK_NS
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input cni_pkg::cni_evt_t evt,
    input cni_pkg::cni_net_cfg_t net_cfg,
    output logic call_alert_n_out,
    output logic ring_notify_out,
    output logic network_status_led_out
);
    import cni_pkg::*;

    typedef struct packed {
        cni_ring_st_t st;
        logic [`CNI_MS_W-1:0] ms;
        logic [`CNI_MS_W-1:0] led_ms;
        logic alert_n;
        logic notify;
        logic led;
    } cni_top_state_t;

    cni_top_state_t s_q;
    cni_top_state_t s_d;
    logic tick;
    logic tick_clr;
    cni_pat_t pat;

    function automatic cni_pat_t led_pat(input cni_net_cfg_t cfg);
        cni_pat_t p;
        p.per = `CNI_DEF_PER_MS;
        p.on = `CNI_DEF_ON_MS;
        if (cfg.pattern_en) begin // [R7]
            case (cfg.state)
                NET_SEARCH: begin
                    p.per = `CNI_SRCH_PER_MS;
                    p.on = `CNI_SRCH_ON_MS;
                end
                NET_REG: begin
                    p.per = `CNI_REG_PER_MS;
                    p.on = `CNI_REG_ON_MS;
                end
                NET_DATA: begin
                    p.per = `CNI_DATA_PER_MS;
                    p.on = `CNI_DATA_ON_MS;
                end
                default: begin
                    p.per = `CNI_DEF_PER_MS;
                    p.on = `CNI_DEF_ON_MS;
                end
            endcase
        end
        return p;
    endfunction : led_pat

    // restarting the prescaler at each pulse start makes widths exact;
    // the led phase jitters by under one ms at those moments
    cni_ms_tick #(
        .TICK_CYC(TICK_CYC)
    ) u_tick (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .clr(tick_clr),
        .tick_q(tick)
    );

    assign pat = led_pat(net_cfg);

    // ********************************
    // alert sequencer and led pwm
    // ********************************
    always_comb begin
        s_d = s_q;
        s_d.notify = 1'b0;
        tick_clr = 1'b0;
        case (s_q.st)
            RING_IDLE: begin
                s_d.alert_n = 1'b1; // [R8]
                if (evt.call_ringing) begin
                    s_d.st = RING_CALL_LOW; // [R1]
                    s_d.ms = '0;
                    s_d.alert_n = 1'b0;
                    s_d.notify = 1'b1; // [R4]
                    tick_clr = 1'b1;
                end else if (evt.sms_arrived) begin
                    s_d.st = RING_SMS_LOW; // [R5]
                    s_d.ms = '0;
                    s_d.alert_n = 1'b0;
                    tick_clr = 1'b1;
                end
            end
            RING_CALL_LOW: begin
                if (!evt.call_ringing) begin
                    s_d.st = RING_IDLE; // [R3]
                    s_d.alert_n = 1'b1;
                end else if (tick) begin
                    s_d.ms = s_q.ms + `CNI_MS_W'(1);
                    if (s_q.ms == `CNI_CALL_LOW_MS - `CNI_MS_W'(1)) begin // [R1]
                        s_d.st = RING_CALL_HIGH;
                        s_d.alert_n = 1'b1;
                    end
                end
            end
            RING_CALL_HIGH: begin
                if (!evt.call_ringing) begin
                    s_d.st = RING_IDLE; // [R3]
                    s_d.alert_n = 1'b1;
                end else if (tick) begin
                    s_d.ms = s_q.ms + `CNI_MS_W'(1);
                    if (s_q.ms == `CNI_CALL_PER_MS - `CNI_MS_W'(1)) begin // [R2]
                        s_d.st = RING_CALL_LOW;
                        s_d.ms = '0;
                        s_d.alert_n = 1'b0;
                        s_d.notify = 1'b1; // [R4]
                        tick_clr = 1'b1;
                    end
                end
            end
            RING_SMS_LOW: begin
                // a call arriving now waits for this short pulse to end
                if (tick) begin
                    s_d.ms = s_q.ms + `CNI_MS_W'(1);
                    if (s_q.ms == `CNI_SMS_LOW_MS - `CNI_MS_W'(1)) begin // [R5]
                        s_d.st = RING_IDLE;
                        s_d.alert_n = 1'b1;
                    end
                end
            end
            default: begin
                s_d.st = RING_IDLE;
                s_d.alert_n = 1'b1;
            end
        endcase

        if (net_cfg.state == NET_OFF) begin
            s_d.led_ms = '0;
            s_d.led = 1'b0;
        end else begin
            // wrap test uses >= so a shorter pattern chosen mid-cycle recovers
            if (s_q.led_ms >= pat.per) begin
                s_d.led_ms = '0;
            end else if (tick) begin
                if (s_q.led_ms >= pat.per - `CNI_MS_W'(1)) begin
                    s_d.led_ms = '0;
                end else begin
                    s_d.led_ms = s_q.led_ms + `CNI_MS_W'(1);
                end
            end
            s_d.led = (s_d.led_ms < pat.on); // [R6]
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_q.st <= RING_IDLE;
            s_q.ms <= '0;
            s_q.led_ms <= '0;
            s_q.alert_n <= 1'b1; // [R8]
            s_q.notify <= 1'b0;
            s_q.led <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign call_alert_n_out = s_q.alert_n;
    assign ring_notify_out = s_q.notify;
    assign network_status_led_out = s_q.led;

    // ********************************
    // checks
    // ********************************
    logic [`CNI_MS_W-1:0] low_ticks_q;
    logic [`CNI_MS_W-1:0] high_ticks_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            low_ticks_q <= '0;
            high_ticks_q <= '0;
        end else begin
            low_ticks_q <= s_q.alert_n ? '0 : (low_ticks_q + (tick ? `CNI_MS_W'(1) : '0));
            high_ticks_q <= !s_q.alert_n ? '0 : (high_ticks_q + (tick ? `CNI_MS_W'(1) : '0));
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_call_low_len;
        ($rose(call_alert_n_out) && s_q.st == RING_CALL_HIGH) |-> low_ticks_q == `CNI_CALL_LOW_MS;
    endproperty
    a_call_low_len: assert property (p_call_low_len) else $error("call low pulse not 30 ticks"); // [R1]

    property p_call_period;
        ($fell(call_alert_n_out) && $past(s_q.st) == RING_CALL_HIGH)
            |-> high_ticks_q == `CNI_CALL_PER_MS - `CNI_CALL_LOW_MS;
    endproperty
    a_call_period: assert property (p_call_period) else $error("call pulse period not 5000 ticks"); // [R2]

    property p_answer_high;
        ($past(s_q.st) inside {RING_CALL_LOW, RING_CALL_HIGH} && !$past(evt.call_ringing))
            |-> call_alert_n_out && s_q.st == RING_IDLE;
    endproperty
    a_answer_high: assert property (p_answer_high) else $error("alert not high after answer"); // [R3]

    property p_notify_with_pulse;
        ring_notify_out |-> $fell(call_alert_n_out) && s_q.st == RING_CALL_LOW;
    endproperty
    a_notify_with_pulse: assert property (p_notify_with_pulse) else $error("ring notice without call pulse"); // [R4]

    property p_sms_len;
        ($rose(call_alert_n_out) && $past(s_q.st) == RING_SMS_LOW) |-> low_ticks_q == `CNI_SMS_LOW_MS ##1
            call_alert_n_out;
    endproperty
    a_sms_len: assert property (p_sms_len) else $error("message pulse not 35 ticks"); // [R5]

    property p_led_off;
        (net_cfg.state == NET_OFF) [*2] |-> !network_status_led_out;
    endproperty
    a_led_off: assert property (p_led_off) else $error("led lit with network off"); // [R6]

    property p_led_duty;
        (net_cfg.state != NET_OFF && $stable(net_cfg) && s_q.led_ms < pat.per)
            |-> network_status_led_out == (s_q.led_ms < pat.on);
    endproperty
    a_led_duty: assert property (p_led_duty) else $error("led level disagrees with pattern phase"); // [R6]

    property p_pat_bound;
        ($stable(net_cfg) && $past(net_cfg, 2) == $past(net_cfg)) |-> s_q.led_ms < pat.per;
    endproperty
    a_pat_bound: assert property (p_pat_bound) else $error("led phase beyond selected period"); // [R7]

    property p_idle_high;
        s_q.st == RING_IDLE |-> call_alert_n_out;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("alert low while idle"); // [R8]

    c_call_cycle: cover property ($fell(call_alert_n_out) && $past(s_q.st) == RING_CALL_HIGH);
    c_sms_pulse: cover property ($rose(call_alert_n_out) && $past(s_q.st) == RING_SMS_LOW);
    c_answered: cover property ($past(s_q.st) == RING_CALL_HIGH && s_q.st == RING_IDLE);
    c_led_blink: cover property (net_cfg.pattern_en && $fell(network_status_led_out));

endmodule : cni_indicator

// ==== core/cni_ms_tick.sv ====
`timescale 1ns/10ps
`include "cni_regs.svh"

module cni_ms_tick #(
    parameter int unsigned TICK_CYC = `CNI_TICK_NS / `CNI_CLK_NS
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clr,
    output logic tick_q
);
    import cni_pkg::*;

    typedef struct packed {
        logic [`CNI_TICK_W-1:0] cnt;
        logic tick;
    } cni_tick_state_t;

    cni_tick_state_t s_q;
    cni_tick_state_t s_d;

    // ********************************
    // prescaler
    // ********************************
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (clr) begin
            // the clearing cycle counts as the first, so widths come out exact
            s_d.cnt = `CNI_TICK_W'(1); // [R9]
        end else if (s_q.cnt == `CNI_TICK_W'(TICK_CYC - 1)) begin // [R9]
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + `CNI_TICK_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_q = s_q.tick;

    // ********************************
    // checks
    // ********************************
    property p_tick_spacing;
        @(posedge clk_sys) disable iff (!rstn)
        tick_q |-> $past(s_q.cnt) == `CNI_TICK_W'(TICK_CYC - 1);
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("ms tick not at full prescale count"); // [R9]

endmodule : cni_ms_tick

// ==== core/cni_pkg.sv ====
`include "cni_regs.svh"

package cni_pkg;

    typedef enum logic [3:0] {
        RING_IDLE = 4'b0001,
        RING_CALL_LOW = 4'b0010,
        RING_CALL_HIGH = 4'b0100,
        RING_SMS_LOW = 4'b1000
    } cni_ring_st_t;

    typedef enum logic [1:0] {
        NET_OFF = 2'h0,
        NET_SEARCH = 2'h1,
        NET_REG = 2'h2,
        NET_DATA = 2'h3
    } cni_net_t;

    typedef struct packed {
        logic call_ringing;
        logic sms_arrived;
    } cni_evt_t;

    typedef struct packed {
        logic pattern_en;
        cni_net_t state;
    } cni_net_cfg_t;

    typedef struct packed {
        logic [`CNI_MS_W-1:0] per;
        logic [`CNI_MS_W-1:0] on;
    } cni_pat_t;

endpackage : cni_pkg

// ==== core/cni_regs.svh ====
`ifndef CNI_REGS_SVH
`define CNI_REGS_SVH

// ********************************
// clock and tick
// ********************************
`define CNI_CLK_NS 32'h0000_0019
`define CNI_TICK_NS 32'h000F_4240
`define CNI_TICK_W 16

// ********************************
// call alert timing, in ms ticks
// ********************************
`define CNI_MS_W 13
`define CNI_CALL_LOW_MS 13'h001E
`define CNI_CALL_PER_MS 13'h1388
`define CNI_SMS_LOW_MS 13'h0023

// ********************************
// network led patterns, in ms ticks
// ********************************
`define CNI_DEF_PER_MS 13'h0320
`define CNI_DEF_ON_MS 13'h0040
`define CNI_SRCH_PER_MS 13'h03E8
`define CNI_SRCH_ON_MS 13'h01F4
`define CNI_REG_PER_MS 13'h0BB8
`define CNI_REG_ON_MS 13'h0040
`define CNI_DATA_PER_MS 13'h00C8
`define CNI_DATA_ON_MS 13'h0064

`endif
